// *** tti_pkg.sv ***
// Package: register layout, field positions and timing constants for the trigger input conditioner
package tti_pkg;
    localparam logic [11:0] ADDR_SLAVE_MODE_CONTROL = 12'h008;
    localparam logic [11:0] ADDR_TRIGGER_STATUS     = 12'h00C;
    localparam logic [15:0] SMC_RESET               = 16'h0000;
    localparam int          SFS_LSB                 = 0;
    localparam int          TSS_LSB                 = 4;
    localparam int          MSS_BIT                 = 7;
    localparam int          ETF_LSB                 = 8;
    localparam int          ETP_LSB                 = 12;
    localparam int          ECM2_BIT                = 14;
    localparam int          EXT_TRIGGER_POLARITY_BIT               = 15;
    localparam logic [2:0]  SFS_EXT_CLOCK_MODE1     = 3'h7;
    localparam logic [2:0]  TSS_EXT_TRIGGER         = 3'h7;
    localparam logic [3:0]  ETF_OFF                 = 4'h0;
    localparam logic [31:0] PSLVERR_DATA            = 32'h0000_0000;
    localparam int          CLK_HZ                  = 50000000;
endpackage

// *** tti_sync.sv ***
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module tti_sync (
    input  wire logic CLK,
    input  wire logic RST_N,
    input  wire logic d,
    output logic      q
);
    logic stage1;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            stage1 <= 1'b0;
            q      <= 1'b0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule // tti_sync

// *** tti_filter.sv ***
// Digital filter: sample at CLK/div, output moves after len agreeing samples
`timescale 1ns/1ps
module tti_filter (
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic [3:0] cfg,
    input  wire logic       d,
    output logic            q
);
    logic [5:0] div;
    logic [3:0] len;
    logic [4:0] pre;
    logic [3:0] cnt;
    logic       tick;

    // ---------------------------------------------------------------
    // Code decode
    // ---------------------------------------------------------------
    always_comb begin
        case (cfg)
            4'h0:    begin div = 6'h01; len = 4'h1; end
            4'h1:    begin div = 6'h01; len = 4'h2; end
            4'h2:    begin div = 6'h01; len = 4'h4; end
            4'h3:    begin div = 6'h01; len = 4'h8; end
            4'h4:    begin div = 6'h02; len = 4'h6; end
            4'h5:    begin div = 6'h02; len = 4'h8; end
            4'h6:    begin div = 6'h04; len = 4'h6; end
            4'h7:    begin div = 6'h04; len = 4'h8; end
            4'h8:    begin div = 6'h08; len = 4'h6; end
            4'h9:    begin div = 6'h08; len = 4'h8; end
            4'hA:    begin div = 6'h10; len = 4'h5; end
            4'hB:    begin div = 6'h10; len = 4'h6; end
            4'hC:    begin div = 6'h10; len = 4'h8; end
            4'hD:    begin div = 6'h20; len = 4'h5; end
            4'hE:    begin div = 6'h20; len = 4'h6; end
            default: begin div = 6'h20; len = 4'h8; end
        endcase
    end

    // Sample strobe; the dead-time sample clock equals CLK here
    assign tick = (pre >= 5'(div - 6'h01));

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre <= 5'h00;
        end else if (tick) begin
            pre <= 5'h00;
        end else begin
            pre <= pre + 5'h01;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt <= 4'h0;
            q   <= 1'b0;
        end else if (tick) begin
            if (d == q) begin
                cnt <= 4'h0;
            end else if (cnt + 4'h1 >= len) begin
                cnt <= 4'h0;
                q   <= d;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule // tti_filter

// *** tti_top.sv ***
// Top: APB slave-mode control register, trigger select and external trigger conditioning
`timescale 1ns/1ps
module tti_top (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        EXT_TRIGGER_PIN,
    input  wire logic        TIMER_INSTANCE_FIFTEEN,
    input  wire logic        INTERNAL_TRIGGER_1,
    input  wire logic        TIMER_INSTANCE_THREE,
    input  wire logic        TIMER_INSTANCE_SEVENTEEN,
    input  wire logic        CH1_EDGE_DETECT,
    input  wire logic        CH1_FILTERED_INPUT,
    input  wire logic        CH2_FILTERED_INPUT,
    output logic             TRIGGER_INPUT,
    output logic             EXT_TRIGGER_FILTERED,
    output logic             EXT_CLOCK_TICK,
    output logic [2:0]       SLAVE_FUNCTION_SELECT,
    output logic             MASTER_SLAVE_SYNC_ENABLE
);
    logic [15:0] slave_mode_control;
    logic        pin_sync;
    logic        pol_level;
    logic        pol_prev;
    logic [2:0]  pre_cnt;
    logic        ext_trigger_prescaled;
    logic        filt_q;
    logic        next_trigger;
    logic        clk_src;
    logic        clk_src_prev;
    logic        wr_en;
    logic        rd_en;
    logic [2:0]  tss;
    logic [1:0]  etp;
    logic        ecm1;
    logic        ecm2;

    // ---------------------------------------------------------------
    // APB register access
    // ---------------------------------------------------------------
    // Zero wait states: PREADY is high from the first clock after reset, access completes in the access phase
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && !PENABLE && !PWRITE;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            slave_mode_control <= tti_pkg::SMC_RESET;
        end else if (wr_en && PADDR == tti_pkg::ADDR_SLAVE_MODE_CONTROL) begin
            slave_mode_control <= PWDATA[15:0];
        end
    end

    // Read data is registered in the setup phase so it is valid in the access phase
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA  <= tti_pkg::PSLVERR_DATA;
            PSLVERR <= 1'b0;
            PREADY  <= 1'b0;
        end else begin
            PREADY <= 1'b1;
            if (PSEL && !PENABLE) begin
                if (PADDR == tti_pkg::ADDR_SLAVE_MODE_CONTROL) begin
                    PRDATA  <= {16'h0000, slave_mode_control};
                    PSLVERR <= 1'b0;
                end else if (PADDR == tti_pkg::ADDR_TRIGGER_STATUS && rd_en) begin
                    PRDATA  <= {29'h0000_0000, EXT_TRIGGER_FILTERED, ext_trigger_prescaled, TRIGGER_INPUT};
                    PSLVERR <= 1'b0;
                end else if (PADDR == tti_pkg::ADDR_TRIGGER_STATUS) begin
                    PRDATA  <= tti_pkg::PSLVERR_DATA;
                    PSLVERR <= 1'b1;
                end else begin
                    PRDATA  <= tti_pkg::PSLVERR_DATA;
                    PSLVERR <= 1'b1;
                end
            end
        end
    end

    assign tss  = slave_mode_control[tti_pkg::TSS_LSB +: 3];
    assign etp  = slave_mode_control[tti_pkg::ETP_LSB +: 2];
    assign ecm1 = slave_mode_control[tti_pkg::SFS_LSB +: 3] == tti_pkg::SFS_EXT_CLOCK_MODE1;
    assign ecm2 = slave_mode_control[tti_pkg::ECM2_BIT];

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SLAVE_FUNCTION_SELECT    <= 3'h0;
            MASTER_SLAVE_SYNC_ENABLE <= 1'b0;
        end else begin
            SLAVE_FUNCTION_SELECT    <= slave_mode_control[tti_pkg::SFS_LSB +: 3];
            MASTER_SLAVE_SYNC_ENABLE <= slave_mode_control[tti_pkg::MSS_BIT];
        end
    end

    // ---------------------------------------------------------------
    // External trigger path
    // ---------------------------------------------------------------
    tti_sync u_pin_sync (
        .CLK   (CLK),
        .RST_N (RST_N),
        .d     (EXT_TRIGGER_PIN),
        .q     (pin_sync)
    );

    assign pol_level = pin_sync ^ slave_mode_control[tti_pkg::EXT_TRIGGER_POLARITY_BIT];

    // Prescaler toggles its output on active edges; divide by 2 needs one toggle per edge.
    // Input above a quarter of CLK cannot be resolved after synchronisation.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pol_prev              <= 1'b0;
            pre_cnt               <= 3'h0;
            ext_trigger_prescaled <= 1'b0;
        end else begin
            pol_prev <= pol_level;
            if (etp == 2'h0) begin
                ext_trigger_prescaled <= pol_level;
                pre_cnt               <= 3'h0;
            end else if (pol_level && !pol_prev) begin
                pre_cnt <= pre_cnt + 3'h1;
                case (etp)
                    2'h1:    ext_trigger_prescaled <= ~ext_trigger_prescaled;
                    2'h2:    if (pre_cnt[0]) ext_trigger_prescaled <= ~ext_trigger_prescaled;
                    default: if (pre_cnt[1:0] == 2'h3) ext_trigger_prescaled <= ~ext_trigger_prescaled;
                endcase
            end
        end
    end

    tti_filter u_filter (
        .CLK   (CLK),
        .RST_N (RST_N),
        .cfg   (slave_mode_control[tti_pkg::ETF_LSB +: 4]),
        .d     (ext_trigger_prescaled),
        .q     (filt_q)
    );

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            EXT_TRIGGER_FILTERED <= 1'b0;
        end else begin
            EXT_TRIGGER_FILTERED <= filt_q;
        end
    end

    // ---------------------------------------------------------------
    // Trigger source selection
    // ---------------------------------------------------------------
    // Internal triggers and channel signals come from this clock domain
    always_comb begin
        case (tss)
            3'h0:    next_trigger = TIMER_INSTANCE_FIFTEEN;
            3'h1:    next_trigger = INTERNAL_TRIGGER_1;
            3'h2:    next_trigger = TIMER_INSTANCE_THREE;
            3'h3:    next_trigger = TIMER_INSTANCE_SEVENTEEN;
            3'h4:    next_trigger = CH1_EDGE_DETECT;
            3'h5:    next_trigger = CH1_FILTERED_INPUT;
            3'h6:    next_trigger = CH2_FILTERED_INPUT;
            default: next_trigger = filt_q;
        endcase
    end

    // Mode 2 overrides mode 1's source; selection changes with the slave disabled
    assign clk_src = ecm2 ? filt_q : next_trigger;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TRIGGER_INPUT  <= 1'b0;
            clk_src_prev   <= 1'b0;
            EXT_CLOCK_TICK <= 1'b0;
        end else begin
            TRIGGER_INPUT  <= next_trigger;
            clk_src_prev   <= clk_src;
            EXT_CLOCK_TICK <= (ecm1 || ecm2) && clk_src && !clk_src_prev;
        end
    end
endmodule // tti_top

// *** tti_asserts.sv ***
// Checker: port-level properties of the trigger input conditioner
`timescale 1ns/1ps
module tti_asserts (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        TIMER_INSTANCE_FIFTEEN,
    input wire logic        INTERNAL_TRIGGER_1,
    input wire logic        TIMER_INSTANCE_THREE,
    input wire logic        TIMER_INSTANCE_SEVENTEEN,
    input wire logic        CH1_EDGE_DETECT,
    input wire logic        CH1_FILTERED_INPUT,
    input wire logic        CH2_FILTERED_INPUT,
    input wire logic        TRIGGER_INPUT,
    input wire logic        EXT_CLOCK_TICK,
    input wire logic [2:0]  SLAVE_FUNCTION_SELECT,
    input wire logic        MASTER_SLAVE_SYNC_ENABLE
);
    localparam logic [11:0] A_SMC = tti_pkg::ADDR_SLAVE_MODE_CONTROL;
    localparam logic [11:0] A_ST  = tti_pkg::ADDR_TRIGGER_STATUS;
    logic [15:0] smc;
    logic [6:0]  srcs;
    logic        acc;
    logic        mode_on;
    assign acc = PSEL && PENABLE && PREADY;
    assign mode_on = smc[14] || smc[2:0] == 3'h7;
    assign srcs = {CH2_FILTERED_INPUT, CH1_FILTERED_INPUT, CH1_EDGE_DETECT, TIMER_INSTANCE_SEVENTEEN,
                   TIMER_INSTANCE_THREE, INTERNAL_TRIGGER_1, TIMER_INSTANCE_FIFTEEN};
    // Shadow of the control register, updated only at the completing edge
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) smc <= 16'h0000;
        else if (acc && PWRITE && PADDR == A_SMC) smc <= PWDATA[15:0];
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_sel; $past(RST_N) && $past(smc[6:4]) != 3'h7 |-> TRIGGER_INPUT == $past(srcs[smc[6:4]]); endproperty
    a_sel: assert property (p_sel) else $error("trigger input does not follow source");
    property p_sfs; $past(RST_N) && smc == $past(smc) |-> SLAVE_FUNCTION_SELECT == smc[2:0]; endproperty
    a_sfs: assert property (p_sfs) else $error("slave function output wrong");
    property p_mss; $past(RST_N) && smc == $past(smc) |-> MASTER_SLAVE_SYNC_ENABLE == smc[7]; endproperty
    a_mss: assert property (p_mss) else $error("sync enable output wrong");
    property p_rdy; $past(RST_N) |-> PREADY; endproperty
    a_rdy: assert property (p_rdy) else $error("ready low after reset");
    property p_rd; acc && !PWRITE && PADDR == A_SMC |-> PRDATA == {16'h0000, smc} && !PSLVERR; endproperty
    a_rd: assert property (p_rd) else $error("control read data wrong");
    property p_err; acc && PADDR != A_SMC && PADDR != A_ST |-> PSLVERR && PRDATA == 32'h0000_0000; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_wst; acc && PWRITE && PADDR == A_ST |-> PSLVERR; endproperty
    a_wst: assert property (p_wst) else $error("status write not refused");
    property p_pulse; EXT_CLOCK_TICK |=> !EXT_CLOCK_TICK; endproperty
    a_pulse: assert property (p_pulse) else $error("clock tick longer than one cycle");
    property p_tsrc; EXT_CLOCK_TICK |-> mode_on || $past(mode_on) || $past(mode_on, 2); endproperty
    a_tsrc: assert property (p_tsrc) else $error("clock tick without external clock mode");
    cover property (acc && PSLVERR);
    cover property (EXT_CLOCK_TICK && smc[14]);
    cover property (acc && !PWRITE && PADDR == A_SMC);
endmodule // tti_asserts

bind tti_top tti_asserts u_chk (.*);

// *** tti_partner.sv ***
// Far side: external trigger pin and trigger levels of the other timer instances
`timescale 1ns/1ps
module tti_partner (
    input  wire logic       CLK,
    input  wire logic [6:0] lvl,
    input  wire logic       pin_lvl,
    input  wire logic [7:0] half,
    output logic            EXT_TRIGGER_PIN,
    output logic [6:0]      src
);
    logic [7:0] cnt;
    initial begin
        EXT_TRIGGER_PIN = 1'b0;
        src = 7'h00;
        cnt = 8'h00;
    end
    always @(posedge CLK) begin
        src <= lvl;
        cnt <= (cnt + 8'h01 >= half) ? 8'h00 : cnt + 8'h01;
        // Half period of two or more keeps the pin at a quarter of CLK at most
        if (half == 8'h00) EXT_TRIGGER_PIN <= pin_lvl;
        else if (cnt + 8'h01 >= half) EXT_TRIGGER_PIN <= !EXT_TRIGGER_PIN;
    end
endmodule // tti_partner

// *** test_timer_trigger_input_conditioning.sv ***
// Testbench: register access, trigger selection, prescaler and filter timing
`timescale 1ns/1ps
module test_timer_trigger_input_conditioning;
    logic CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, PREADY, PSLVERR;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0000_0000, PRDATA, r;
    logic EXT_TRIGGER_PIN, TIMER_INSTANCE_FIFTEEN, INTERNAL_TRIGGER_1, TIMER_INSTANCE_THREE;
    logic TIMER_INSTANCE_SEVENTEEN, CH1_EDGE_DETECT, CH1_FILTERED_INPUT, CH2_FILTERED_INPUT, e;
    logic TRIGGER_INPUT, EXT_TRIGGER_FILTERED, EXT_CLOCK_TICK, MASTER_SLAVE_SYNC_ENABLE, pin_lvl = 1'b0;
    logic [2:0] SLAVE_FUNCTION_SELECT;
    logic [6:0] lvl = 7'h00, src;
    logic [7:0] half = 8'h00;
    logic [15:0] v;
    int num_errors = 0, checked = 0, d, k, x;
    assign {CH2_FILTERED_INPUT, CH1_FILTERED_INPUT, CH1_EDGE_DETECT, TIMER_INSTANCE_SEVENTEEN,
            TIMER_INSTANCE_THREE, INTERNAL_TRIGGER_1, TIMER_INSTANCE_FIFTEEN} = src;
    tti_top dut (.*);
    tti_partner u_far (.CLK(CLK), .lvl(lvl), .pin_lvl(pin_lvl), .half(half),
                       .EXT_TRIGGER_PIN(EXT_TRIGGER_PIN), .src(src));
    always #10 CLK = ~CLK;
    task automatic finish_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin @(posedge CLK); n++; end while (PREADY !== 1'b1 && n < 50);
        if (n >= 50) begin chk(0, 1); finish_test(); end
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    function automatic logic [31:0] cfg(input logic pol, c2, input logic [1:0] p, input logic [3:0] f,
                                        input logic [2:0] t, s);
        return {16'h0000, pol, c2, p, f, 1'b0, t, 1'b0, s};
    endfunction
    function automatic int fdiv(input logic [3:0] c);
        return c < 4 ? 1 : c < 6 ? 2 : c < 8 ? 4 : c < 10 ? 8 : c < 13 ? 16 : 32;
    endfunction
    function automatic int flen(input logic [3:0] c);
        return c == 0 ? 1 : c < 4 ? 2 << (c - 1) : c < 10 ? (c[0] ? 8 : 6) : c inside {10, 13} ? 5
               : c inside {11, 14} ? 6 : 8;
    endfunction
    task automatic wait_f(input logic val, input int lim);
        d = 0;
        while (EXT_TRIGGER_FILTERED !== val && d < lim) begin @(posedge CLK); d++; end
        if (d >= lim) begin chk(0, 1); finish_test(); end
    endtask
    initial begin
        void'($urandom(32'h3E90));
        repeat (12) @(posedge CLK);
        RST_N <= 1'b1;
        apb(0, 12'h008, 0);
        chk(r, {16'h0000, tti_pkg::SMC_RESET});
        repeat (4) begin
            v = 16'($urandom);
            // Keep the trigger select fixed while the slave function is random
            v[6:4] = 3'h0;
            apb(1, 12'h008, {16'hFFFF, v});
            apb(0, 12'h008, 0);
            chk(r, {16'h0000, v});
            chk(SLAVE_FUNCTION_SELECT, v[2:0]);
            chk(MASTER_SLAVE_SYNC_ENABLE, v[7]);
        end
        apb(0, 12'h010, 0);
        chk(r, 32'h0000_0000);
        chk(e, 1);
        apb(1, 12'h00C, 0);
        chk(e, 1);
        $display("register test done");
        for (x = 0; x < 14; x++) begin
            lvl <= 7'($urandom);
            apb(1, 12'h008, cfg(0, 0, 0, 0, 3'(x % 7), 0));
            repeat (3) @(posedge CLK);
            chk(TRIGGER_INPUT, lvl[x % 7]);
        end
        $display("select test done");
        for (x = 0; x < 16; x++) begin
            apb(1, 12'h008, cfg(0, 0, 0, 4'(x), 7, 0));
            wait_f(0, 400);
            pin_lvl <= 1'b1;
            wait_f(1, 400);
            chk(d >= fdiv(x) * (flen(x) - 1) + 1 && d <= fdiv(x) * flen(x) + 8, 1);
            chk(TRIGGER_INPUT, 1);
            apb(0, tti_pkg::ADDR_TRIGGER_STATUS, 0);
            chk(r, 32'h0000_0007);
            pin_lvl <= 1'b0;
        end
        @(posedge CLK);
        pin_lvl <= 1'b1;
        apb(1, 12'h008, cfg(1, 0, 0, 0, 7, 0));
        wait_f(0, 20);
        $display("filter test done");
        half <= 8'h02;
        for (x = -1; x < 4; x++) begin
            apb(1, 12'h008, cfg(0, x > 0, 2'(x), 0, 7, x == 1 || x < 0 ? 0 : 7));
            repeat (40) @(posedge CLK);
            k = 0;
            repeat (512) begin @(posedge CLK); k += EXT_CLOCK_TICK; end
            d = x < 0 ? 0 : 128 >> x;
            chk(k >= d - 1 && k <= d + 1, 1);
        end
        $display("prescaler test done");
        finish_test();
    end
endmodule // test_timer_trigger_input_conditioning
